// file: logic/mcfi_params.svh
// Constants for the motion command frame interpreter
`ifndef MCFI_PARAMS_SVH
`define MCFI_PARAMS_SVH
// Frame lengths in bytes
`define MCFI_SER_LEN 4'h9
`define MCFI_CAN_LEN 4'h7
`define MCFI_CORE_LEN 4'h7
// Reply status codes
`define MCFI_ST_OK 8'h64
`define MCFI_ST_STORED 8'h65
`define MCFI_ST_BAD_SUM 8'h01
`define MCFI_ST_INV_CMD 8'h02
`define MCFI_ST_WRONG_TYPE 8'h03
`define MCFI_ST_INV_VALUE 8'h04
`define MCFI_ST_LOCKED 8'h05
`define MCFI_ST_NOT_AVAIL 8'h06
// Flow control command numbers kept inside the block while a stored program runs
`define MCFI_OP_CALC 8'h13
`define MCFI_OP_COMP 8'h14
`define MCFI_OP_JC 8'h15
`define MCFI_OP_JA 8'h16
`define MCFI_OP_STOP 8'h1C
// Arithmetic operation types
`define MCFI_CALC_ADD 8'h00
`define MCFI_CALC_SUB 8'h01
`define MCFI_CALC_LOAD 8'h02
// Jump condition types
`define MCFI_JC_EQ 8'h00
`define MCFI_JC_NE 8'h01
`define MCFI_JC_GT 8'h02
`endif

// file: logic/mcfi_pkg.sv
// Types shared by the motion command frame interpreter
package mcfi_pkg;
   // Seven-byte command core
   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] typ;
      logic [7:0] bank;
      logic [31:0] value;
   } mcfi_cmd_s;
   // Executor answer
   typedef struct packed {
      logic [7:0] status;
      logic [31:0] value;
   } mcfi_result_s;
   // Interpreter states
   typedef enum logic [2:0] {
      ST_RX,
      ST_EXEC,
      ST_REPLY,
      ST_PSTEP,
      ST_PEXEC
   } mcfi_state_e;
endpackage

// file: logic/mcfi_interp.sv
// Command frame interpreter with receive FIFO and program store
`include "mcfi_params.svh"

// Byte FIFO between the link and the frame parser
module mcfi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   // Honest full and empty
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage write
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module mcfi_interp #(
   parameter int FIFO_DEPTH = 4,
   parameter int PROG_DEPTH = 64
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic can_mode,
   input wire logic [7:0] module_addr,
   input wire logic [7:0] reply_addr,
   input wire logic store_mode,
   input wire logic prog_run,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_drive,
   output logic exec_valid,
   output mcfi_pkg::mcfi_cmd_s exec_cmd,
   input wire logic exec_done,
   input wire mcfi_pkg::mcfi_result_s exec_result,
   output logic prog_busy
);
   localparam int PW = $clog2(PROG_DEPTH);

   // Sum of the low eight bytes of a nine-byte frame
   function automatic logic [7:0] sum8(input logic [71:0] f);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 8; i++) begin
         s = s + f[i*8 +: 8];
      end
      return s;
   endfunction

   // Reply image, first byte in the low lane
   function automatic logic [71:0] build_reply(input logic can, input logic [7:0] ra,
                                               input logic [7:0] ma, input logic [7:0] st,
                                               input logic [7:0] cmd, input logic [31:0] v);
      logic [71:0] f;
      f = {8'h00, v[7:0], v[15:8], v[23:16], v[31:24], cmd, st, ma, ra};
      if (can) begin
         f = {8'h00, f[71:8]};
      end else begin
         f[71:64] = sum8(f);
      end
      return f;
   endfunction

   mcfi_pkg::mcfi_state_e state_r;
   logic [7:0] byte_d;
   logic byte_v;
   logic byte_take;
   logic [3:0] cnt_r;
   logic [3:0] frame_len;
   logic [7:0] addr_r;
   logic [7:0] sum_r;
   logic [55:0] core_r;
   logic [55:0] core_nxt;
   logic [55:0] core_full;
   logic last_byte;
   logic for_us;
   logic sum_ok;
   mcfi_pkg::mcfi_cmd_s xcmd_r;
   logic [71:0] sh_r;
   logic [3:0] txcnt_r;
   logic [PW-1:0] pc_r;
   logic [PW-1:0] wr_r;
   mcfi_pkg::mcfi_cmd_s pmem [PROG_DEPTH];
   logic halted_r;
   logic [31:0] acc_r;
   logic [31:0] cmp_ref_r;
   logic prog_start;
   logic jump_taken;
   logic store_now;
   logic exec_now;
   logic bad_now;

   // Input FIFO stalls the link while a frame executes or replies
   mcfi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_data),
      .out_valid(byte_v),
      .out_ready(byte_take),
      .out_data(byte_d)
   );

   // Frame collection decode
   assign prog_start = (state_r == mcfi_pkg::ST_RX) && (cnt_r == 4'h0) && prog_run && !halted_r;
   assign byte_take = (state_r == mcfi_pkg::ST_RX) && !prog_start;
   assign frame_len = can_mode ? `MCFI_CAN_LEN : `MCFI_SER_LEN;
   assign last_byte = byte_take && byte_v && (cnt_r == frame_len - 4'h1);
   assign core_nxt = {core_r[47:0], byte_d};
   assign core_full = can_mode ? core_nxt : core_r;
   assign for_us = can_mode || (addr_r == module_addr);
   assign sum_ok = can_mode || (byte_d == sum_r);
   assign store_now = last_byte && for_us && sum_ok && store_mode;
   assign exec_now = last_byte && for_us && sum_ok && !store_mode;
   assign bad_now = last_byte && for_us && !sum_ok;

   // Byte counter, address, running sum and core capture
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= 4'h0;
         addr_r <= 8'h00;
         sum_r <= 8'h00;
         core_r <= '0;
      end else if (byte_take && byte_v) begin
         if (last_byte) begin
            cnt_r <= 4'h0;
            sum_r <= 8'h00;
         end else begin
            cnt_r <= cnt_r + 4'h1;
            sum_r <= sum_r + byte_d;
         end
         if (!can_mode && cnt_r == 4'h0) begin
            addr_r <= byte_d;
         end else if (!(last_byte && !can_mode)) begin
            core_r <= core_nxt;
         end
      end
   end

   // Program memory writes in store mode
   always_ff @(posedge clock) begin
      if (store_now) begin
         pmem[wr_r] <= core_full;
      end
   end

   // Program write pointer restarts whenever store mode drops
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_r <= '0;
      end else if (!store_mode) begin
         wr_r <= '0;
      end else if (store_now) begin
         wr_r <= wr_r + 1'b1;
      end
   end

   // Condition of a jump against the last compare
   always_comb begin
      jump_taken = 1'b0;
      if (xcmd_r.cmd == `MCFI_OP_JA) begin
         jump_taken = 1'b1;
      end else if (xcmd_r.cmd == `MCFI_OP_JC) begin
         unique case (xcmd_r.typ)
            `MCFI_JC_EQ: jump_taken = (acc_r == cmp_ref_r);
            `MCFI_JC_NE: jump_taken = (acc_r != cmp_ref_r);
            `MCFI_JC_GT: jump_taken = ($signed(acc_r) > $signed(cmp_ref_r));
            default: jump_taken = 1'b0;
         endcase
      end
   end

   // Main sequence: collect, execute, reply, or step the stored program
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= mcfi_pkg::ST_RX;
         xcmd_r <= '0;
         sh_r <= '0;
         txcnt_r <= 4'h0;
      end else begin
         unique case (state_r)
            mcfi_pkg::ST_RX: begin
               if (prog_start) begin
                  xcmd_r <= pmem[pc_r];
                  state_r <= mcfi_pkg::ST_PSTEP;
               end else if (exec_now) begin
                  xcmd_r <= core_full;
                  state_r <= mcfi_pkg::ST_EXEC;
               end else if (store_now) begin
                  sh_r <= build_reply(can_mode, reply_addr, module_addr,
                                      `MCFI_ST_STORED, core_full[55:48], core_full[31:0]);
                  txcnt_r <= frame_len;
                  state_r <= mcfi_pkg::ST_REPLY;
               end else if (bad_now) begin
                  sh_r <= build_reply(1'b0, reply_addr, module_addr,
                                      `MCFI_ST_BAD_SUM, core_r[55:48], 32'h00000000);
                  txcnt_r <= frame_len;
                  state_r <= mcfi_pkg::ST_REPLY;
               end
            end
            mcfi_pkg::ST_EXEC: begin
               if (exec_done) begin
                  sh_r <= build_reply(can_mode, reply_addr, module_addr, exec_result.status,
                                      xcmd_r.cmd, exec_result.value);
                  txcnt_r <= frame_len;
                  state_r <= mcfi_pkg::ST_REPLY;
               end
            end
            mcfi_pkg::ST_REPLY: begin
               if (tx_ready) begin
                  sh_r <= {8'h00, sh_r[71:8]};
                  txcnt_r <= txcnt_r - 4'h1;
                  if (txcnt_r == 4'h1) begin
                     state_r <= mcfi_pkg::ST_RX;
                  end
               end
            end
            mcfi_pkg::ST_PSTEP: begin
               if (xcmd_r.cmd == `MCFI_OP_CALC || xcmd_r.cmd == `MCFI_OP_COMP ||
                   xcmd_r.cmd == `MCFI_OP_JC || xcmd_r.cmd == `MCFI_OP_JA ||
                   xcmd_r.cmd == `MCFI_OP_STOP) begin
                  state_r <= mcfi_pkg::ST_RX;
               end else begin
                  state_r <= mcfi_pkg::ST_PEXEC;
               end
            end
            mcfi_pkg::ST_PEXEC: begin
               if (exec_done) begin
                  state_r <= mcfi_pkg::ST_RX;
               end
            end
         endcase
      end
   end

   // Program counter, accumulator, compare reference and halt flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc_r <= '0;
         acc_r <= 32'h00000000;
         cmp_ref_r <= 32'h00000000;
         halted_r <= 1'b0;
      end else if (!prog_run) begin
         pc_r <= '0;
         halted_r <= 1'b0;
      end else if (state_r == mcfi_pkg::ST_PSTEP) begin
         if (xcmd_r.cmd == `MCFI_OP_CALC) begin
            unique case (xcmd_r.typ)
               `MCFI_CALC_ADD: acc_r <= acc_r + xcmd_r.value;
               `MCFI_CALC_SUB: acc_r <= acc_r - xcmd_r.value;
               `MCFI_CALC_LOAD: acc_r <= xcmd_r.value;
               default: acc_r <= acc_r;
            endcase
         end
         if (xcmd_r.cmd == `MCFI_OP_COMP) begin
            cmp_ref_r <= xcmd_r.value;
         end
         if (xcmd_r.cmd == `MCFI_OP_STOP) begin
            halted_r <= 1'b1;
         end else if (jump_taken) begin
            pc_r <= xcmd_r.value[PW-1:0];
         end else if (xcmd_r.cmd == `MCFI_OP_CALC || xcmd_r.cmd == `MCFI_OP_COMP ||
                      xcmd_r.cmd == `MCFI_OP_JC) begin
            pc_r <= pc_r + 1'b1;
         end
      end else if (state_r == mcfi_pkg::ST_PEXEC && exec_done) begin
         pc_r <= pc_r + 1'b1;
      end
   end

   // Executor and link outputs
   assign exec_valid = (state_r == mcfi_pkg::ST_EXEC) || (state_r == mcfi_pkg::ST_PEXEC);
   assign exec_cmd = xcmd_r;
   assign tx_valid = (state_r == mcfi_pkg::ST_REPLY);
   assign tx_drive = tx_valid;
   assign tx_data = sh_r[7:0];
   assign prog_busy = prog_run && !halted_r;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_reply_after_exec: assert property (
      (state_r == mcfi_pkg::ST_EXEC && exec_done) |=> tx_valid)
      else $error("reply did not follow execution");
   a_drive_only_reply: assert property (
      tx_drive |-> state_r == mcfi_pkg::ST_REPLY)
      else $error("bus driven outside a reply");
   a_no_exec_on_reply: assert property (
      tx_valid |-> !exec_valid)
      else $error("executing during reply");
   a_bad_sum_status: assert property (
      bad_now |=> tx_valid && tx_data == reply_addr && sh_r[23:16] == `MCFI_ST_BAD_SUM)
      else $error("bad checksum not answered with status 1");
   a_bad_sum_no_exec: assert property (
      bad_now |=> !exec_valid)
      else $error("bad frame executed");
   a_store_status: assert property (
      store_now |=> sh_r[23:16] == `MCFI_ST_STORED || (can_mode && sh_r[15:8] == 8'h65))
      else $error("stored command status not 101");
   a_reply_cksum: assert property (
      (state_r == mcfi_pkg::ST_REPLY && !can_mode && txcnt_r == 4'h9)
      |-> sh_r[71:64] == sum8(sh_r))
      else $error("reply checksum wrong");
   a_reply_length: assert property (
      ($rose(tx_valid) && !can_mode) |=> tx_valid [*8])
      else $error("serial reply shorter than nine cycles");
   a_cmd_echo: assert property (
      (state_r == mcfi_pkg::ST_EXEC && exec_done && !can_mode)
      |=> sh_r[31:24] == $past(xcmd_r.cmd))
      else $error("command number not echoed");
   a_can_exec: assert property (
      (exec_now && can_mode) |=> exec_valid && exec_cmd == $past(core_nxt))
      else $error("CAN core not executed");

   c_serial_ok: cover property (exec_now && !can_mode ##[1:40] tx_valid);
   c_bad_sum: cover property (bad_now);
   c_store: cover property (store_now);
   c_prog_jump: cover property (state_r == mcfi_pkg::ST_PSTEP && jump_taken);
endmodule

// file: bench/mcfi_host.sv
// Host model: offers command bytes in order and collects reply bytes
module mcfi_host (
   input wire logic clock,
   input wire logic rst,
   input wire logic slow,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] send_q[$];
   logic [7:0] got_q[$];

   // Hold each byte until it is taken; idle data changes every cycle
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end else if (!rx_valid || rx_ready) begin
         if (send_q.size() > 0) begin
            rx_valid <= 1'b1;
            rx_data <= send_q.pop_front();
         end else begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
         end
      end
   end

   // Accept reply bytes, only every other cycle when slow
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_ready <= 1'b1;
      end else begin
         tx_ready <= slow ? ~tx_ready : 1'b1;
         if (tx_valid && tx_ready) got_q.push_back(tx_data);
      end
   end
endmodule

// file: bench/mcfi_interp_bench.sv
// Self-checking bench for the command frame interpreter
module mcfi_interp_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic can_mode = 1'b0;
   logic [7:0] module_addr = 8'h2A;
   logic [7:0] reply_addr = 8'h02;
   logic store_mode = 1'b0;
   logic prog_run = 1'b0;
   logic slow = 1'b0;
   logic exec_done = 1'b0;
   logic rx_valid, rx_ready, tx_valid, tx_ready, tx_drive, exec_valid, prog_busy;
   logic [7:0] rx_data, tx_data;
   mcfi_pkg::mcfi_cmd_s exec_cmd, ex_seen;
   mcfi_pkg::mcfi_result_s exec_result = '0;
   mcfi_pkg::mcfi_cmd_s c = '{8'h05, 8'h04, 8'h02, 32'h1234ABCD};
   logic [7:0] ex_status = 8'h64;
   logic [31:0] ex_value = 32'hDEADBEEF;
   int ex_wait = 0;
   int ex_count = 0;
   int err_total = 0;
   int tests_run = 0;

   // Clock of 100 MHz
   always #5 clock = ~clock;

   mcfi_host host (.clock(clock), .rst(rst), .slow(slow), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data));

   mcfi_interp #(.FIFO_DEPTH(4), .PROG_DEPTH(64)) dut (.clock(clock), .rst(rst),
      .can_mode(can_mode), .module_addr(module_addr), .reply_addr(reply_addr),
      .store_mode(store_mode), .prog_run(prog_run), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_drive(tx_drive), .exec_valid(exec_valid),
      .exec_cmd(exec_cmd), .exec_done(exec_done), .exec_result(exec_result),
      .prog_busy(prog_busy));

   // Executor stand-in: answers each command three cycles after it appears
   always @(posedge clock) begin
      exec_done <= 1'b0;
      if (exec_valid && !exec_done) begin
         if (ex_wait >= 2) begin
            exec_done <= 1'b1;
            exec_result <= {ex_status, ex_value};
            ex_seen <= exec_cmd;
            ex_count <= ex_count + 1;
            ex_wait <= 0;
         end else begin
            ex_wait <= ex_wait + 1;
         end
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Build a frame, with its checksum in serial mode, optionally corrupted
   task automatic send_cmd(input logic [7:0] adr, input logic bad);
      logic [7:0] b[$];
      logic [7:0] sum;
      b = {c.cmd, c.typ, c.bank, c.value[31:24], c.value[23:16], c.value[15:8], c.value[7:0]};
      if (!can_mode) begin
         b.push_front(adr);
         sum = 8'h00;
         foreach (b[i]) sum += b[i];
         b.push_back(sum ^ {7'h00, bad});
      end
      host.got_q.delete();
      foreach (b[i]) host.send_q.push_back(b[i]);
   endtask

   // Wait for a whole reply, then make sure nothing more follows
   task automatic get_reply(input int n);
      for (int k = 0; k < 400 && host.got_q.size() < n; k++) @(posedge clock);
      repeat (40) @(posedge clock);
      chk("reply length", n, host.got_q.size());
      chk("bus released", 0, tx_drive);
   endtask

   task automatic chk_reply(input logic [7:0] st, input logic chkv);
      int o;
      logic [7:0] sum;
      o = can_mode ? 0 : 1;
      if (!can_mode) begin
         sum = 8'h00;
         for (int i = 0; i < 8; i++) sum += host.got_q[i];
         chk("reply address", reply_addr, host.got_q[0]);
         chk("reply checksum", sum, host.got_q[8]);
      end
      chk("module address", module_addr, host.got_q[o]);
      chk("status", st, host.got_q[o+1]);
      chk("command echo", c.cmd, host.got_q[o+2]);
      if (chkv) chk("value", ex_value, {host.got_q[o+3], host.got_q[o+4],
         host.got_q[o+5], host.got_q[o+6]});
   endtask

   // Plain command is executed once, then answered once
   task automatic t_ok();
      int n;
      n = ex_count;
      ex_status = 8'h64;
      send_cmd(module_addr, 1'b0);
      get_reply(9);
      chk("executed", n + 1, ex_count);
      chk("exec fields", c[55:24], ex_seen[55:24]);
      chk("exec value", c.value, ex_seen.value);
      chk_reply(8'h64, 1'b1);
   endtask

   // Corrupted checksum and foreign address are not executed
   task automatic t_reject();
      int n;
      n = ex_count;
      ex_value = 32'h0;
      send_cmd(module_addr, 1'b1);
      get_reply(9);
      chk_reply(8'h01, 1'b1);
      send_cmd(module_addr ^ 8'h01, 1'b0);
      get_reply(0);
      chk("not executed", n, ex_count);
      ex_value = 32'hDEADBEEF;
   endtask

   // Executor errors pass through while the host stalls
   task automatic t_errors();
      slow <= 1'b1;
      for (int s = 2; s <= 6; s++) begin
         ex_status = s[7:0];
         send_cmd(module_addr, 1'b0);
         get_reply(9);
         chk_reply(s[7:0], 1'b1);
      end
      slow <= 1'b0;
   endtask

   // CAN framing: seven bytes in, seven bytes out
   task automatic t_can();
      can_mode <= 1'b1;
      @(posedge clock);
      ex_status = 8'h64;
      send_cmd(module_addr, 1'b0);
      get_reply(7);
      chk_reply(8'h64, 1'b1);
      can_mode <= 1'b0;
      @(posedge clock);
   endtask

   // Store one command; it is answered 101 and not run
   task automatic store_one(input logic [7:0] cm, input logic [7:0] ty, input logic [31:0] v);
      c = '{cm, ty, 8'h00, v};
      send_cmd(module_addr, 1'b0);
      get_reply(9);
      chk_reply(8'h65, 1'b0);
   endtask

   // Store load, compare, equal jump over one command, a command and a halt, then run
   task automatic t_prog();
      int n;
      n = ex_count;
      store_mode <= 1'b1;
      @(posedge clock);
      store_one(8'h13, 8'h02, 32'h00000005);
      store_one(8'h14, 8'h00, 32'h00000005);
      store_one(8'h15, 8'h00, 32'h00000004);
      store_one(8'h05, 8'h04, 32'h1234ABCD);
      store_one(8'h06, 8'h01, 32'h00000000);
      store_one(8'h1C, 8'h00, 32'h00000000);
      chk("stored not run", n, ex_count);
      store_mode <= 1'b0;
      @(posedge clock);
      host.got_q.delete();
      prog_run <= 1'b1;
      @(posedge clock);
      for (int k = 0; k < 300 && prog_busy !== 1'b0; k++) @(posedge clock);
      chk("program halted", 0, prog_busy);
      chk("program executed", n + 1, ex_count);
      chk("program command", 8'h06, ex_seen.cmd);
      chk("no reply", 0, host.got_q.size());
      prog_run <= 1'b0;
      @(posedge clock);
   endtask

   task automatic finish_test();
      $display("Checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Reset for three cycles, then the scenarios
   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_ok();
      t_reject();
      t_ok();
      t_errors();
      t_can();
      t_prog();
      finish_test();
   end

   // Watchdog against a hang
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
endmodule
